// File: hdl/dual_interp_mod.sv
// Interpolating complex modulator datapath, sample FIFO and filter stage.
// Assumes core_clk is the DAC sample clock and the source keeps headroom.
//
// How it works
// - Ratios 1, 2, 4 and 8 are offered, ratio 1 bypassing every halfband stage.
// - Stage one is a 55-tap halfband with centre 32768 and inner taps 20755.
// - Stage two is a 23-tap halfband with centre 4096 and odd outer taps.
// - Stage three is a 15-tap halfband with centre 8192 and odd taps.
// - The inverse sinc stage is 9 symmetric taps around a centre of 401.
// - Complex input can be moved to positive or negative output zones.
// - Shifted modes centre the passband on odd halves of the input rate.
// - Shifted modes move the passband only, never the signal position.
// - In dual mode port one carries I and port two carries Q together.
// - Outputs are the input times a carrier at a multiple of DAC rate over 4, 8 or 16.
// - Bit 6 of register 0x02 selects I, Q interleaved data on port one.
// - Interleaved data gives each of I and Q half the port sample rate.
// - Bit 5 of register 0x02 turns off Q and modulation, leaving real I.
// - Register 0x01 holds the ratio in bits 7:6 and the mode in bits 5:2.

////////////////////////////////////////////////////////////////////////////
module iq_fifo
#(
    parameter int W = 32,
    parameter int DEPTH = 4
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic rdy_q;
    wire logic push = ce && in_valid && rdy_q;
    wire logic pop = ce && out_valid && out_ready;

    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign in_ready = rdy_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end
        else if (ce)
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data;
                wr_q <= wr_q + AW'(1);
            end
            if (pop)
                rd_q <= rd_q + AW'(1);
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != (AW+1)'(DEPTH);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module filt_sym
    import interp_pkg::*;
#(
    parameter int M = 1,
    parameter int STEP = 1,
    parameter int SIDE [M] = '{default: 0},
    parameter int CTR = 1,
    parameter int SH = 0
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic ld,
    input wire iq_t din,
    output iq_t dout
);
    localparam int C = STEP * (M - 1) + 1;
    localparam int NT = 2 * C + 1;
    iq_t tap_q [NT];
    logic signed [47:0] acc_i;
    logic signed [47:0] acc_q;

    // Folded symmetric sum
    always_comb
    begin
        acc_i = 48'(CTR) * 48'(tap_q[C].i);
        acc_q = 48'(CTR) * 48'(tap_q[C].q);
        for (int m = 0; m < M; m++)
        begin
            acc_i = acc_i + 48'(SIDE[m])
                * (48'(tap_q[STEP*m].i) + 48'(tap_q[NT-1-STEP*m].i));
            acc_q = acc_q + 48'(SIDE[m])
                * (48'(tap_q[STEP*m].q) + 48'(tap_q[NT-1-STEP*m].q));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int k = 0; k < NT; k++)
                tap_q[k] <= '0;
            dout <= '0;
        end
        else if (ce && ld)
        begin
            tap_q[0] <= din;
            for (int k = 1; k < NT; k++)
                tap_q[k] <= tap_q[k-1];
            dout <= '{i: sat16(acc_i >>> SH), q: sat16(acc_q >>> SH)};
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module dual_interp_mod
    import interp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic signed [15:0] port1_data,
    input wire logic signed [15:0] port2_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic signed [15:0] dac_i,
    output logic signed [15:0] dac_q,
    output logic dac_valid
);
    logic [7:0] interp_q;
    logic [7:0] path_q;
    logic under_q;
    logic [2:0] cnt_q;
    logic [3:0] phase_q;
    logic half_q;
    logic flip_q;
    logic signed [15:0] hold_q;
    iq_t src_q;
    iq_t mod_q;
    iq_t fifo_out;
    iq_t push_data;
    iq_t src_d;
    iq_t sinc_out;
    iq_t lin [1:3];
    iq_t fv [1:3];
    iq_t sv [0:3];
    logic [3:1] ld;
    logic [3:1] ins;
    logic fifo_rdy;
    logic fifo_valid;
    logic [2:0] fifo_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Configuration decode
    wire logic [1:0] fl = interp_q[FACT_LO +: 2];
    wire logic real_on = path_q[REAL_BIT];
    wire logic ilv_on = path_q[ILV_BIT];
    wire logic sinc_on = path_q[SINC_BIT];
    wire logic mod_on = !real_on && fl != 2'h0;
    wire logic [2:0] nmask = 3'((4'h1 << fl) - 4'h1);
    wire logic [3:0] mode_m = interp_q[MODE_LO +: 4]
        & 4'((5'h02 << fl) - 5'h01);
    wire logic [3:0] inc = 4'({1'b0, mode_m[3:1]} << (3'h4 - {1'b0, fl}))
        + 4'({3'h0, mode_m[0]} << (3'h3 - {1'b0, fl}));
    wire logic [2:0] cnt_d = (cnt_q == nmask) ? 3'h0 : cnt_q + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Input port and FIFO
    wire logic accept = ce && in_valid && fifo_rdy;
    wire logic push = accept && (!ilv_on || half_q);
    wire logic pop = ce && cnt_q == 3'h0;
    wire logic under_set = pop && !fifo_valid;
    wire logic st_rd = ce && reg_rd && reg_addr == ADDR_STATUS;
    // I on port one, Q on two or after I on port one
    assign push_data = ilv_on ? '{i: hold_q, q: port1_data}
        : '{i: port1_data, q: port2_data};
    assign in_ready = fifo_rdy;

    iq_fifo #(.W($bits(iq_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_rdy),
        .in_data(push_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_out),
        .level(fifo_lvl)
    );

    // pre-rotate by half the input rate
    wire logic neg = mod_on && mode_m[0] && flip_q;
    // Q channel dropped in real mode
    assign src_d.i = !fifo_valid ? 16'sh0000
        : neg ? sat16(-48'(fifo_out.i)) : fifo_out.i;
    assign src_d.q = (!fifo_valid || real_on) ? 16'sh0000
        : neg ? sat16(-48'(fifo_out.q)) : fifo_out.q;

    ////////////////////////////////////////////////////////////////////////
    // Halfband cascade
    assign sv[0] = src_q;
    for (genvar j = 1; j < 4; j++)
    begin : g_stage
        wire logic [2:0] p = 3'((4'h1 << fl) >> j);
        assign ld[j] = ce && fl >= 2'(j) && (cnt_q & (p - 3'h1)) == 3'h0;
        assign ins[j] = (cnt_q & p) != 3'h0;
        assign lin[j] = ins[j] ? sv[j-1] : '0;
        assign sv[j] = (fl >= 2'(j)) ? fv[j] : sv[j-1];
    end

    filt_sym #(.M(LPF1_M), .STEP(HB_STEP), .SIDE(LPF1_SIDE),
        .CTR(LPF1_CTR), .SH(LPF1_SH)) u_lpf1 (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .ld(ld[1]),
        .din(lin[1]),
        .dout(fv[1])
    );
    filt_sym #(.M(LPF2_M), .STEP(HB_STEP), .SIDE(LPF2_SIDE),
        .CTR(LPF2_CTR), .SH(LPF2_SH)) u_lpf2 (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .ld(ld[2]),
        .din(lin[2]),
        .dout(fv[2])
    );
    filt_sym #(.M(LPF3_M), .STEP(HB_STEP), .SIDE(LPF3_SIDE),
        .CTR(LPF3_CTR), .SH(LPF3_SH)) u_lpf3 (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .ld(ld[3]),
        .din(lin[3]),
        .dout(fv[3])
    );

    ////////////////////////////////////////////////////////////////////////
    // Complex carrier
    wire logic signed [15:0] cosv = 16'(COS16[phase_q]);
    wire logic signed [15:0] sinv = 16'(COS16[4'(phase_q - PH_QTR)]);
    // wrapping phase step reaches negative zones
    wire logic signed [47:0] rot_i = (48'(sv[3].i) * 48'(cosv)
        - 48'(sv[3].q) * 48'(sinv)) >>> ROT_SH;
    wire logic signed [47:0] rot_q = (48'(sv[3].i) * 48'(sinv)
        + 48'(sv[3].q) * 48'(cosv)) >>> ROT_SH;

    filt_sym #(.M(SINC_M), .STEP(SINC_STEP), .SIDE(SINC_SIDE),
        .CTR(SINC_CTR), .SH(SINC_SH)) u_sinc (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .ld(1'b1),
        .din(mod_q),
        .dout(sinc_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port
    // register decode
    wire logic [7:0] rd_mux = (reg_addr == ADDR_INTERP) ? interp_q
        : (reg_addr == ADDR_PATH) ? path_q
        : (reg_addr == ADDR_STATUS) ? {under_q, 4'h0, fifo_lvl} : 8'h00;
    wire logic wr_interp = reg_wr && reg_addr == ADDR_INTERP;
    wire logic wr_path = reg_wr && reg_addr == ADDR_PATH;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            interp_q <= 8'h00;
            path_q <= 8'h00;
            reg_rdata <= 8'h00;
            under_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_interp)
                interp_q <= reg_wdata;
            if (wr_path)
                path_q <= reg_wdata & PATH_MASK;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            under_q <= under_set || (under_q && !st_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cnt_q <= 3'h0;
            half_q <= 1'b0;
            hold_q <= 16'sh0000;
            flip_q <= 1'b0;
            src_q <= '0;
        end
        else if (ce)
        begin
            cnt_q <= cnt_d;
            if (!ilv_on)
                half_q <= 1'b0;
            else if (accept)
                half_q <= !half_q;
            if (accept && !half_q)
                hold_q <= port1_data;
            if (pop)
            begin
                src_q <= src_d;
                flip_q <= !flip_q;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            phase_q <= 4'h0;
            mod_q <= '0;
            dac_i <= 16'sh0000;
            dac_q <= 16'sh0000;
            dac_valid <= 1'b0;
        end
        else
        begin
            dac_valid <= ce;
            if (ce)
            begin
                phase_q <= mod_on ? phase_q + inc : 4'h0;
                if (mod_on)
                    mod_q <= '{i: sat16(rot_i), q: sat16(rot_q)};
                else
                    mod_q <= '{i: sv[3].i, q: real_on ? 16'sh0000 : sv[3].q};
                dac_i <= sinc_on ? sinc_out.i : mod_q.i;
                dac_q <= real_on ? 16'sh0000
                    : sinc_on ? sinc_out.q : mod_q.q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_pop_phase:
        assert property (ce && pop && fl == 2'h3 && !wr_interp |=> !pop)
        else $error("sample taken off phase");
    a_bypass_idle:
        assert property (fl == 2'h0 |-> ld == 3'h0)
        else $error("filter loaded in bypass");
    a_real_q_zero:
        assert property (ce && real_on |=> mod_q.q == 16'sh0000)
        else $error("Q live in real mode");
    a_ilv_pair:
        assert property (accept && ilv_on |-> push == half_q)
        else $error("interleave pairing wrong");
    a_dual_push:
        assert property (accept && !ilv_on |-> push)
        else $error("dual sample not pushed");
    a_ilv_rate:
        assert property (push && ilv_on |=> !push)
        else $error("interleave pushed too fast");
    a_reg_readback:
        assert property (ce && reg_rd && reg_addr == ADDR_INTERP
            |=> reg_rdata == $past(interp_q))
        else $error("mode register readback wrong");
    a_phase_idle:
        assert property (ce && !mod_on |=> phase_q == 4'h0)
        else $error("carrier running while off");
endmodule

// File: hdl/interp_pkg.sv
// Types, register map and fixed filter constants of the interpolator.
// Assumes an 8-bit register port with 5-bit addresses.
package interp_pkg;
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } iq_t;
    localparam logic [4:0] ADDR_INTERP = 5'h01;
    localparam logic [4:0] ADDR_PATH = 5'h02;
    localparam logic [4:0] ADDR_STATUS = 5'h1C;
    localparam int FACT_LO = 6;
    localparam int MODE_LO = 2;
    localparam int ILV_BIT = 6;
    localparam int REAL_BIT = 5;
    localparam int SINC_BIT = 0;
    localparam logic [7:0] PATH_MASK = 8'h61;
    localparam int FIFO_DEPTH = 4;
    localparam int HB_STEP = 2;
    localparam int SINC_STEP = 1;
    localparam int LPF1_M = 14;
    localparam int LPF1_SIDE [LPF1_M] = '{-4, 13, -34, 72, -138, 245, -408,
        650, -1003, 1521, -2315, 3671, -6642, 20755};
    localparam int LPF1_CTR = 32768;
    localparam int LPF1_SH = 15;
    localparam int LPF2_M = 6;
    localparam int LPF2_SIDE [LPF2_M] = '{-2, 17, -75, 238, -660, 2530};
    localparam int LPF2_CTR = 4096;
    localparam int LPF2_SH = 12;
    localparam int LPF3_M = 4;
    localparam int LPF3_SIDE [LPF3_M] = '{-39, 273, -1102, 4964};
    localparam int LPF3_CTR = 8192;
    localparam int LPF3_SH = 13;
    localparam int SINC_M = 4;
    localparam int SINC_SIDE [SINC_M] = '{2, -4, 10, -35};
    localparam int SINC_CTR = 401;
    localparam int SINC_SH = 8;
    localparam int ROT_SH = 14;
    localparam int COS16 [16] = '{16384, 15137, 11585, 6270, 0, -6270,
        -11585, -15137, -16384, -15137, -11585, -6270, 0, 6270, 11585, 15137};
    localparam logic [3:0] PH_QTR = 4'h4;
    localparam logic signed [47:0] SMP_MAX = 48'sh7FFF;
    localparam logic signed [47:0] SMP_MIN = -48'sh8000;

    function automatic logic signed [15:0] sat16(
        input logic signed [47:0] v);
        if (v > SMP_MAX)
            return 16'sh7FFF;
        if (v < SMP_MIN)
            return 16'sh8000;
        return v[15:0];
    endfunction
endpackage

// File: testbench/iq_source.sv
// Sample source model standing in front of the interpolator input port.
// Assumes one clock and srst shared with the design; ce held high.
module iq_source
    import interp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic in_ready,
    input wire logic run,
    input wire logic ilv,
    input wire logic tone,
    input wire logic shot,
    input wire iq_t lvl,
    output logic signed [15:0] port1_data,
    output logic signed [15:0] port2_data,
    output logic in_valid,
    output int taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] n_q;
    logic half_q;
    logic signed [15:0] ci;
    logic signed [15:0] cq;
    // bench picks levels well below full scale
    assign ci = (shot && n_q != 16'h0000) ? 16'sh0000 : !tone ? lvl.i :
        n_q[0] ? 16'sh0000 : n_q[1] ? -lvl.i : lvl.i;
    assign cq = (shot && n_q != 16'h0000) ? 16'sh0000 : !tone ? lvl.q :
        !n_q[0] ? 16'sh0000 : n_q[1] ? -lvl.i : lvl.i;
    // I on port one, Q on port two or after I
    assign port1_data = !in_valid ? ~ci : (ilv && half_q) ? cq : ci;
    assign port2_data = (!in_valid || ilv) ? ~cq : cq;
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            n_q <= 16'h0000;
            half_q <= 1'b0;
            in_valid <= 1'b0;
            taken <= 0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                half_q <= ilv && !half_q;
                taken <= taken + 1;
                if (!ilv || half_q)
                    n_q <= n_q + 16'h0001;
            end
            else if (!in_valid && !run)
                n_q <= 16'h0000;
            in_valid <= run || (in_valid && !in_ready);
        end
    end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the interpolating complex modulator.
// Assumes the package, design and source model are compiled first.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s exp=%0d got=%0d", nm, e, g); end end
module tb_top
    import interp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rv;
    logic signed [15:0] port1_data, port2_data, dac_i, dac_q;
    logic in_valid, in_ready, dac_valid;
    logic run = 0, ilv = 0, tone = 0, shot = 0;
    iq_t lvl = '0;
    int taken, err_total = 0, n_checks = 0, cyc = 0, t0, f, nf, km;
    logic signed [15:0] cap_i [192];
    int sinc_e [9] = '{2, -4, 10, -35, 401, -35, 10, -4, 2};
    logic [8:0] rows [19] = '{9'h001, 9'h089, 9'h081, 9'h090, 9'h099,
        9'h110, 9'h130, 9'h120, 9'h129, 9'h190, 9'h199, 9'h1B0, 9'h1D0,
        9'h1F0, 9'h1F9, 9'h189, 9'h1C0, 9'h1A0, 9'h1E0};
    dual_interp_mod dual_interp_mod_inst (.core_clk(core_clk), .srst(srst),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port1_data(port1_data),
        .port2_data(port2_data), .in_valid(in_valid), .in_ready(in_ready),
        .dac_i(dac_i), .dac_q(dac_q), .dac_valid(dac_valid));
    iq_source iq_source_inst (.core_clk(core_clk), .srst(srst),
        .in_ready(in_ready), .run(run), .ilv(ilv), .tone(tone), .shot(shot),
        .lvl(lvl), .port1_data(port1_data), .port2_data(port2_data),
        .in_valid(in_valid), .taken(taken));
    initial
        forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rst();
        @(posedge core_clk);
        srst <= 1;
        repeat (5) @(posedge core_clk);
        srst <= 0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 rv = reg_rdata;
    endtask
    task automatic near(input string nm, input int e,
        input logic signed [15:0] g, input int tol);
        logic signed [31:0] gv;
        logic ok;
        gv = g;
        ok = !$isunknown(g) && gv - e <= tol && e - gv <= tol;
        `CHK(nm, e, ok ? 32'(e) : gv)
    endtask
    task automatic rot(input real k, input int amp);
        logic signed [15:0] i0, q0, mag;
        real c, s;
        @(posedge core_clk);
        #1 i0 = dac_i;
        q0 = dac_q;
        c = $cos(3.14159265 * k / 8.0);
        s = $sin(3.14159265 * k / 8.0);
        mag = 16'($rtoi($sqrt(real'(i0) ** 2 + real'(q0) ** 2)));
        @(posedge core_clk);
        #1 near("mag", amp, mag, 80);
        near("rot_i", $rtoi(i0 * c - q0 * s), dac_i, 80);
        near("rot_q", $rtoi(i0 * s + q0 * c), dac_q, 80);
    endtask
    task automatic impulse(input logic signed [15:0] amp);
        f = -1;
        @(posedge core_clk);
        lvl <= '{i: amp, q: 16'sh0000};
        shot <= 1;
        run <= 1;
        for (int j = 0; j < 192; j++)
        begin
            @(posedge core_clk);
            #1 cap_i[j] = dac_i;
            if (f < 0 && cap_i[j] !== 16'sh0000)
                f = j;
        end
        run <= 0;
        shot <= 0;
    endtask
    function automatic real tap1(input int j);
        if (j == 27)
            return 32768.0;
        if (j == 26 || j == 28)
            return 20755.0;
        if (j % 2 == 1)
            return 0.0;
        return real'(LPF1_SIDE[j < 27 ? j / 2 : (54 - j) / 2]);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst();
        rd(ADDR_INTERP);
        `CHK("interp_rst", 8'h00, rv)
        wr(ADDR_INTERP, 8'hC8);
        wr(ADDR_PATH, 8'hFF);
        wr(5'h05, 8'hFF);
        rd(ADDR_INTERP);
        `CHK("interp", 8'hC8, rv)
        rd(ADDR_PATH);
        `CHK("path", 8'h61, rv)
        @(posedge core_clk);
        #1 `CHK("rd_stand", 8'h00, reg_rdata)
        rd(5'h05);
        `CHK("unmapped", 8'h00, rv)
        rst();
        wr(ADDR_PATH, 8'h01);
        impulse(16'sh0100);
        foreach (sinc_e[j])
            near("sinc", sinc_e[j], cap_i[f + j], 0);
        rst();
        wr(ADDR_INTERP, 8'h40);
        impulse(16'sh2000);
        for (int j = 0; j < 55; j++)
            near("hb1", $rtoi(tap1(j) / 4.0), cap_i[f + j], 1);
        rst();
        lvl <= '{i: 16'sh1770, q: 16'shF448};
        run <= 1;
        foreach (rows[r])
        begin
            wr(ADDR_INTERP, rows[r][8:1]);
            tone <= rows[r][0];
            repeat (600) @(posedge core_clk);
            nf = 1 << rows[r][8:7];
            km = (rows[r][6:3] >> 1) & (nf - 1);
            rot(16.0 * km / nf + (rows[r][0] ? 4.0 / nf : 0.0),
                rows[r][0] ? 6000 : 6708);
        end
        wr(ADDR_PATH, 8'h20);
        wr(ADDR_INTERP, 8'h48);
        tone <= 0;
        repeat (600) @(posedge core_clk);
        repeat (2)
        begin
            @(posedge core_clk);
            #1 near("real_i", 6000, dac_i, 80);
            `CHK("real_q", 16'sh0000, dac_q)
        end
        rst();
        wr(ADDR_PATH, 8'h40);
        wr(ADDR_INTERP, 8'h40);
        ilv <= 1;
        repeat (600) @(posedge core_clk);
        repeat (2)
        begin
            @(posedge core_clk);
            #1 near("ilv_i", 6000, dac_i, 80);
            near("ilv_q", -3000, dac_q, 80);
        end
        rst();
        ilv <= 0;
        wr(ADDR_INTERP, 8'hC0);
        repeat (100) @(posedge core_clk);
        t0 = taken;
        repeat (80) @(posedge core_clk);
        `CHK("rate_8x", 10, taken - t0)
        run <= 0;
        repeat (60) @(posedge core_clk);
        rd(ADDR_STATUS);
        `CHK("drained", 8'h80, rv)
        @(posedge core_clk);
        ce <= 0;
        repeat (2) @(posedge core_clk);
        #1 `CHK("ce_hold", 1'b0, dac_valid)
        ce <= 1;
        repeat (2) @(posedge core_clk);
        #1 `CHK("ce_run", 1'b1, dac_valid)
        test_done();
    end
endmodule
